// [pkg/dee_pkg.sv]
// Operation
// - Address, clear space select, set read strobe; byte appears next cycle.
// - Data register keeps last read byte until next read or software write.
// - Write starts only after 55h then AAh to unlock, then write strobe.
// - Write strobe cannot be set while write permit bit is clear.
// - Hardware never clears the write permit bit.
// - Clearing write permit during a write cycle does not affect it.
// - At write end, hardware clears write strobe and sets write done flag.
// - Protect fuse 0 protects data memory; turning protection off erases all, unless a write is in progress then.
package dee_pkg;
  localparam int          DEE_ADDR_W      = 8;
  localparam int          DEE_DEPTH       = 256;
  localparam logic [7:0]  DEE_UNLOCK_1    = 8'h55;
  localparam logic [7:0]  DEE_UNLOCK_2    = 8'hAA;
  localparam logic [7:0]  DEE_ERASED      = 8'hFF;
  localparam logic [7:0]  DEE_DATA_RST    = 8'h00;
  localparam logic [7:0]  DEE_ADDR_RST    = 8'h00;
  localparam int          DEE_CLK_MHZ     = 100;
  localparam int          DEE_WRITE_US    = 5;
  localparam int          DEE_WRITE_CYC   = DEE_WRITE_US * DEE_CLK_MHZ;
  localparam logic [15:0] DEE_WRITE_CNT   = 16'(DEE_WRITE_CYC);

  typedef enum logic [1:0] {
    DEE_UL_IDLE = 2'b00,
    DEE_UL_GOT1 = 2'b01,
    DEE_UL_OPEN = 2'b10
  } dee_unlock_t;

  typedef enum logic [1:0] {
    DEE_ST_IDLE  = 2'b00,
    DEE_ST_WRITE = 2'b01,
    DEE_ST_ERASE = 2'b10
  } dee_state_t;

  typedef struct packed {
    logic                  we;
    logic [DEE_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  erase_all;
  } dee_mem_req_t;
endpackage : dee_pkg

// [design/dee_array.sv]
`timescale 1ns/10ps
module dee_array
  import dee_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_n_in,
  // Access
  input  wire dee_mem_req_t          req_in,
  input  wire logic [DEE_ADDR_W-1:0] raddr_in,
  output logic [7:0]                 rdata_out
);
  logic [7:0] cell_reg [DEE_DEPTH];

  // Cells model nonvolatile storage, so reset leaves contents alone
  genvar gi;
  generate
    for (gi = 0; gi < DEE_DEPTH; gi++) begin : g_cell
      always_ff @(posedge clk_sys_in) begin
        if (req_in.erase_all) begin
          cell_reg[gi] <= DEE_ERASED;
        end else if (req_in.we && req_in.addr == DEE_ADDR_W'(gi)) begin
          cell_reg[gi] <= req_in.wdata;
        end
      end
    end
  endgenerate

  assign rdata_out = cell_reg[raddr_in];
endmodule : dee_array

// [design/dee_access_ctrl.sv]
`timescale 1ns/10ps
module dee_access_ctrl
  import dee_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_n_in,
  // Address register write
  input  wire logic                  addr_we_in,
  input  wire logic [7:0]            addr_wdata_in,
  // Data register write
  input  wire logic                  data_we_in,
  input  wire logic [7:0]            data_wdata_in,
  // Control register write
  input  wire logic                  ctrl_we_in,
  input  wire logic                  space_sel_wdata_in,
  input  wire logic                  permit_wdata_in,
  input  wire logic                  wr_strobe_wdata_in,
  input  wire logic                  rd_strobe_wdata_in,
  input  wire logic                  done_flag_clr_in,
  // Unlock register write
  input  wire logic                  unlock_we_in,
  input  wire logic [7:0]            unlock_wdata_in,
  // Configuration fuse, from outside the clock domain
  input  wire logic                  data_protect_fuse_in,
  // Register views
  output logic [7:0]                 nvm_address_out,
  output logic [7:0]                 nvm_data_out,
  output logic                       program_space_select_out,
  output logic                       write_permit_bit_out,
  output logic                       write_strobe_out,
  output logic                       write_done_flag_out,
  output logic                       data_protected_out,
  output logic                       erase_busy_out
);
  logic [7:0]   nvm_address_reg;
  logic [7:0]   nvm_data_reg;
  logic         program_space_select_reg;
  logic         write_permit_bit_reg;
  logic         write_strobe_reg;
  logic         write_done_flag_reg;
  logic         fuse_meta_reg;
  logic         fuse_sync_reg;
  logic         fuse_seen_reg;
  logic         fuse_prev_reg;
  logic         erase_busy_reg;
  logic         data_protected_reg;
  logic [15:0]  timer_reg;
  dee_unlock_t  unlock_reg;
  dee_state_t   state_reg;
  dee_mem_req_t mem_req;
  logic [7:0]   mem_rdata;
  logic         any_other_access;
  logic         write_start;
  logic         read_go;
  logic         write_end;
  logic         erase_start;

  assign any_other_access = addr_we_in | data_we_in | ctrl_we_in;
  assign write_start = ctrl_we_in && wr_strobe_wdata_in
                       && !write_strobe_reg && write_permit_bit_reg
                       && unlock_reg == DEE_UL_OPEN
                       && !erase_start
                       && state_reg == DEE_ST_IDLE;
  assign read_go = ctrl_we_in && rd_strobe_wdata_in && !space_sel_wdata_in
                   && state_reg == DEE_ST_IDLE;
  assign write_end = state_reg == DEE_ST_WRITE && timer_reg == 16'h0001;
  // Protection going from on to off, seen on the synchronised fuse
  assign erase_start = fuse_seen_reg && !fuse_prev_reg && fuse_sync_reg
                       && state_reg == DEE_ST_IDLE;

  always_comb begin
    mem_req.we        = write_end;
    mem_req.addr      = nvm_address_reg;
    mem_req.wdata     = nvm_data_reg;
    mem_req.erase_all = erase_start;
  end

  dee_array u_array (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .req_in     (mem_req),
    .raddr_in   (nvm_address_reg),
    .rdata_out  (mem_rdata)
  );

  // Fuse is a pin level: two flops before use
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fuse_meta_reg <= 1'b1;
      fuse_sync_reg <= 1'b1;
      fuse_prev_reg <= 1'b1;
      fuse_seen_reg <= 1'b0;
    end else begin
      fuse_meta_reg <= data_protect_fuse_in;
      fuse_sync_reg <= fuse_meta_reg;
      fuse_prev_reg <= fuse_sync_reg;
      fuse_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nvm_address_reg <= DEE_ADDR_RST;
    end else if (addr_we_in && state_reg != DEE_ST_WRITE) begin
      nvm_address_reg <= addr_wdata_in;
    end
  end

  // Reads use the stored address; software loads it in an earlier cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nvm_data_reg <= DEE_DATA_RST;
    end else if (read_go) begin
      nvm_data_reg <= mem_rdata;
    end else if (data_we_in && state_reg != DEE_ST_WRITE) begin
      nvm_data_reg <= data_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      program_space_select_reg <= 1'b0;
      write_permit_bit_reg     <= 1'b0;
    end else if (ctrl_we_in) begin
      program_space_select_reg <= space_sel_wdata_in;
      write_permit_bit_reg     <= permit_wdata_in;
    end
  end

  // Unlock sequencer: any break in the order drops back to idle
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      unlock_reg <= DEE_UL_IDLE;
    end else if (unlock_we_in) begin
      case (unlock_reg)
        DEE_UL_IDLE: begin
          unlock_reg <= (unlock_wdata_in == DEE_UNLOCK_1) ? DEE_UL_GOT1
                                                          : DEE_UL_IDLE;
        end
        DEE_UL_GOT1: begin
          unlock_reg <= (unlock_wdata_in == DEE_UNLOCK_2) ? DEE_UL_OPEN
                                                          : DEE_UL_IDLE;
        end
        default: begin
          unlock_reg <= (unlock_wdata_in == DEE_UNLOCK_1) ? DEE_UL_GOT1
                                                          : DEE_UL_IDLE;
        end
      endcase
    end else if (any_other_access) begin
      unlock_reg <= DEE_UL_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= DEE_ST_IDLE;
      timer_reg <= 16'h0000;
    end else begin
      case (state_reg)
        DEE_ST_IDLE: begin
          if (erase_start) begin
            state_reg <= DEE_ST_ERASE;
          end else if (write_start) begin
            state_reg <= DEE_ST_WRITE;
            timer_reg <= DEE_WRITE_CNT;
          end
        end
        DEE_ST_WRITE: begin
          // Permit changes are ignored here on purpose
          if (write_end) begin
            state_reg <= DEE_ST_IDLE;
          end
          timer_reg <= timer_reg - 16'h0001;
        end
        default: begin
          state_reg <= DEE_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      write_strobe_reg <= 1'b0;
    end else if (write_start) begin
      write_strobe_reg <= 1'b1;
    end else if (write_end) begin
      write_strobe_reg <= 1'b0;
    end
  end

  // Set beats a clear arriving in the same cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      write_done_flag_reg <= 1'b0;
    end else if (write_end) begin
      write_done_flag_reg <= 1'b1;
    end else if (done_flag_clr_in) begin
      write_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      erase_busy_reg <= 1'b0;
    end else begin
      erase_busy_reg <= erase_start;
    end
  end

  // Protection view is registered so the port comes from a flop
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_protected_reg <= 1'b0;
    end else begin
      data_protected_reg <= ~fuse_sync_reg;
    end
  end

  assign nvm_address_out          = nvm_address_reg;
  assign nvm_data_out             = nvm_data_reg;
  assign program_space_select_out = program_space_select_reg;
  assign write_permit_bit_out     = write_permit_bit_reg;
  assign write_strobe_out         = write_strobe_reg;
  assign write_done_flag_out      = write_done_flag_reg;
  assign data_protected_out       = data_protected_reg;
  assign erase_busy_out           = erase_busy_reg;
endmodule : dee_access_ctrl

// [sim/dee_access_ctrl_sva.sv]
`timescale 1ns/10ps
module dee_access_ctrl_sva
  import dee_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  // Requests
  input wire logic       data_we_in,
  input wire logic       ctrl_we_in,
  input wire logic       wr_strobe_wdata_in,
  input wire logic       rd_strobe_wdata_in,
  input wire logic       done_flag_clr_in,
  input wire logic       unlock_we_in,
  input wire logic [7:0] unlock_wdata_in,
  input wire logic       data_protect_fuse_in,
  // Views
  input wire logic [7:0] nvm_data_out,
  input wire logic       write_permit_bit_out,
  input wire logic       write_strobe_out,
  input wire logic       write_done_flag_out,
  input wire logic       data_protected_out
);
  // Counts sampled busy cycles; too long for a repetition
  logic [15:0] hi_cnt_reg;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) hi_cnt_reg <= 16'h0000;
    else hi_cnt_reg <= write_strobe_out ? hi_cnt_reg + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_key;
    unlock_we_in && unlock_wdata_in == DEE_UNLOCK_1 ##1
    unlock_we_in && unlock_wdata_in == DEE_UNLOCK_2 ##1
    ctrl_we_in && wr_strobe_wdata_in && write_permit_bit_out;
  endsequence
  property p_key; s_key ##0 !write_strobe_out |=> write_strobe_out; endproperty
  a_key: assert property (p_key) else $error("write not started");
  property p_cause; $rose(write_strobe_out) |-> $past(ctrl_we_in) &&
    $past(unlock_we_in && unlock_wdata_in == DEE_UNLOCK_2, 2) &&
    $past(unlock_we_in && unlock_wdata_in == DEE_UNLOCK_1, 3); endproperty
  a_cause: assert property (p_cause) else $error("rogue write");
  property p_gate; ctrl_we_in && wr_strobe_wdata_in && !write_permit_bit_out
    && !write_strobe_out |=> !write_strobe_out; endproperty
  a_gate: assert property (p_gate) else $error("write without permit");
  property p_perm; !ctrl_we_in |=> $stable(write_permit_bit_out); endproperty
  a_perm: assert property (p_perm) else $error("permit changed");
  property p_hold; write_strobe_out && hi_cnt_reg < DEE_WRITE_CYC - 1
    |=> write_strobe_out; endproperty
  a_hold: assert property (p_hold) else $error("write cut short");
  property p_end; $fell(write_strobe_out) |->
    write_done_flag_out && hi_cnt_reg == DEE_WRITE_CNT; endproperty
  a_end: assert property (p_end) else $error("bad write end");
  property p_done; write_done_flag_out && !done_flag_clr_in
    |=> write_done_flag_out; endproperty
  a_done: assert property (p_done) else $error("done flag lost");
  property p_data; !data_we_in && !(ctrl_we_in && rd_strobe_wdata_in)
    |=> $stable(nvm_data_out); endproperty
  a_data: assert property (p_data) else $error("data reg moved");
  property p_fuse; (!data_protect_fuse_in)[*4] |=> data_protected_out;
  endproperty
  a_fuse: assert property (p_fuse) else $error("not protected");
endmodule : dee_access_ctrl_sva

// [sim/tb_dee_access_ctrl.sv]
`timescale 1ns/10ps
module tb_dee_access_ctrl
  import dee_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic addr_we_in, data_we_in, ctrl_we_in, unlock_we_in, done_flag_clr_in;
  logic space_sel_wdata_in, permit_wdata_in;
  logic wr_strobe_wdata_in, rd_strobe_wdata_in;
  logic data_protect_fuse_in = 1'b1;
  logic [7:0] wd, nvm_address_out, nvm_data_out, a, d;
  logic program_space_select_out, write_permit_bit_out, write_strobe_out;
  logic write_done_flag_out, data_protected_out, erase_busy_out;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  always #5 clk_sys_in = ~clk_sys_in;
  dee_access_ctrl dut_u (.clk_sys_in, .reset_n_in, .addr_we_in,
    .addr_wdata_in(wd), .data_we_in, .data_wdata_in(wd), .ctrl_we_in,
    .space_sel_wdata_in, .permit_wdata_in, .wr_strobe_wdata_in,
    .rd_strobe_wdata_in, .done_flag_clr_in, .unlock_we_in,
    .unlock_wdata_in(wd), .data_protect_fuse_in, .nvm_address_out,
    .nvm_data_out, .program_space_select_out, .write_permit_bit_out,
    .write_strobe_out, .write_done_flag_out, .data_protected_out,
    .erase_busy_out);
  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Kinds: 0 addr, 1 data, 2 control, 3 unlock, 4 clear done, 5 idle
  task automatic op(input int k, input logic [7:0] v);
    {addr_we_in, data_we_in, ctrl_we_in, unlock_we_in} =
      {k == 0, k == 1, k == 2, k == 3};
    done_flag_clr_in = (k == 4);
    {space_sel_wdata_in, permit_wdata_in} = v[4:3];
    {wr_strobe_wdata_in, rd_strobe_wdata_in} = v[2:1];
    wd = (k > 4) ? 8'($urandom) : v;
    @(posedge clk_sys_in);
    #1;
  endtask : op
  task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
    op(0, ad);
    chk(16'(nvm_address_out), 16'(ad));
    exp_q.push_back(ex);
    op(2, 8'h02);
  endtask : rd
  task automatic wbyte(input logic [7:0] ad, input logic [7:0] dv, bit drop);
    while (write_strobe_out !== 1'b0) op(5, 8'h00);
    op(0, ad);
    op(1, dv);
    op(2, 8'h08);
    op(3, DEE_UNLOCK_1);
    op(3, DEE_UNLOCK_2);
    op(2, 8'h0C);
    chk(16'(write_strobe_out), 16'h0001);
    n = 0;
    // Drop writes permit 0 and strobe 0 mid-write
    while (write_strobe_out === 1'b1 && n < 600) begin
      op((drop && n == 9) ? 2 : 5, 8'h00);
      n++;
    end
    chk(16'(n), 16'(DEE_WRITE_CYC));
    chk(16'(write_done_flag_out), 16'h0001);
    chk(16'(write_permit_bit_out), 16'(!drop));
  endtask : wbyte
  task automatic bad(int k1, logic [7:0] v1, int k2, logic [7:0] v2,
                     int k3, logic [7:0] v3);
    op(k1, v1);
    op(k2, v2);
    op(k3, v3);
    op(2, 8'h0C);
    chk(16'(write_strobe_out), 16'h0000);
  endtask : bad
  always @(posedge clk_sys_in) begin
    if (ctrl_we_in && rd_strobe_wdata_in && !space_sel_wdata_in) begin
      #2;
      chk(16'(nvm_data_out), 16'(exp_q.pop_front()));
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_mismatch++;
    end_sim();
  end
  initial begin
    n = $urandom(32'hC1F0A1EE);
    repeat (3) op(5, 8'h00);
    reset_n_in = 1'b1;
    chk({nvm_address_out, nvm_data_out}, 16'h0000);
    chk(16'({write_permit_bit_out, write_strobe_out, write_done_flag_out,
      data_protected_out, program_space_select_out}), 16'h0000);
    a = 8'($urandom);
    d = 8'($urandom);
    data_protect_fuse_in = 1'b0;
    repeat (6) op(5, 8'h00);
    chk(16'(data_protected_out), 16'h0001);
    data_protect_fuse_in = 1'b1;
    for (n = 0; n < 50 && erase_busy_out !== 1'b1; n++) op(5, 8'h00);
    chk(16'(erase_busy_out), 16'h0001);
    op(5, 8'h00);
    rd(a + 8'h01, DEE_ERASED);
    wbyte(a, d, 1'b1);
    rd(a, d);
    op(2, 8'h12);
    chk(16'(program_space_select_out), 16'h0001);
    chk(16'(nvm_data_out), 16'(d));
    repeat (4) op(5, 8'h00);
    chk(16'(write_done_flag_out), 16'h0001);
    op(4, 8'h00);
    chk(16'(write_done_flag_out), 16'h0000);
    wbyte(a, ~d, 1'b0);
    op(1, d);
    chk(16'(nvm_data_out), 16'(d));
    op(2, 8'h00);
    bad(5, 8'h00, 3, DEE_UNLOCK_1, 3, DEE_UNLOCK_2);
    bad(3, DEE_UNLOCK_1, 3, 8'h12, 3, DEE_UNLOCK_2);
    bad(3, DEE_UNLOCK_1, 0, a, 3, DEE_UNLOCK_2);
    bad(3, DEE_UNLOCK_1, 3, DEE_UNLOCK_2, 1, d);
    bad(3, DEE_UNLOCK_2, 3, DEE_UNLOCK_1, 5, 8'h00);
    rd(a, ~d);
    op(5, 8'h00);
    end_sim();
  end
endmodule : tb_dee_access_ctrl
bind dee_access_ctrl dee_access_ctrl_sva chk_u (.clk_sys_in, .reset_n_in,
  .data_we_in, .ctrl_we_in, .wr_strobe_wdata_in, .rd_strobe_wdata_in,
  .done_flag_clr_in, .unlock_we_in, .unlock_wdata_in, .data_protect_fuse_in,
  .nvm_data_out, .write_permit_bit_out, .write_strobe_out,
  .write_done_flag_out, .data_protected_out);
